//--- hw/ured_map.svh
// Register offsets, field positions, reset values and timing counts
// for the USB equalization and compliance register bank.
// Assumes nothing beyond a SystemVerilog preprocessor.
`ifndef URED_MAP_SVH
`define URED_MAP_SVH

`define URED_OFS_GENERAL 8'h0a
`define URED_OFS_DOWN_EQ 8'h20
`define URED_OFS_UP_EQ 8'h21
`define URED_OFS_LINK_CTRL 8'h22

`define URED_BIT_TAKEOVER 4
`define URED_BIT_COMPLIANCE_ACTIVE_FLAG 7
`define URED_BIT_LOW_FREQ_SIGNAL_EQ_APPLY 6
`define URED_BIT_EXIT_FILTER 5
`define URED_BIT_PROBE_OFF 4
`define URED_LSB_PERIOD 2
`define URED_LSB_COMPLIANCE 0

`define URED_RST_GENERAL 8'h00
`define URED_RST_DOWN_EQ 8'h00
`define URED_RST_UP_EQ 4'h0
`define URED_RST_LINK_CTRL 8'h00

`define URED_CLK_MHZ 200
`define URED_DEBOUNCE_US 200
`define URED_PROBE_SHORT_MS 8
`define URED_PROBE_LONG_MS 12
`define URED_DEBOUNCE_CYC (`URED_DEBOUNCE_US * `URED_CLK_MHZ)
`define URED_PROBE_SHORT_CYC (`URED_PROBE_SHORT_MS * 1000 * `URED_CLK_MHZ)
`define URED_PROBE_LONG_CYC (`URED_PROBE_LONG_MS * 1000 * `URED_CLK_MHZ)

`endif

//--- hw/ured_pkg.sv
// Types shared by the USB equalization and compliance register bank.
// Assumes ured_map.svh supplies all numeric constants.
`default_nettype none

package ured_pkg;

    typedef logic [3:0] ured_eq_t;

    typedef enum logic [1:0] {
        URED_CM_AUTO,
        URED_CM_DOWNSTREAM,
        URED_CM_UPSTREAM,
        URED_CM_OFF
    } ured_cm_e;

    typedef enum logic [1:0] {
        URED_PERIOD_8MS,
        URED_PERIOD_12MS,
        URED_PERIOD_RSV2,
        URED_PERIOD_RSV3
    } ured_period_e;

    // Equalization applied to the three USB receivers.
    typedef struct packed {
        ured_eq_t upstream;
        ured_eq_t down_a;
        ured_eq_t down_b;
    } ured_eq_s;

endpackage

`default_nettype wire

//--- hw/ured_regs.sv
// USB equalization, link-power and compliance register bank.
// Assumes a register access port driven by the device's serial target
// logic, with one-cycle read and write strobes in the clk domain.
//
// Behaviour
// - Upstream equalization select is four bits, low bits, zero to eleven dB.
// - Takeover clear or pin mode: field shows strap pins; set in register mode: software writes set it.
// - Control bit 7 is read-only compliance status, one when in compliance.
// - Low_freq_signal_eq_apply bit zero forces zero eq during LFPS, else programmed values.
// - Exit filter bit set demands 200 us of LFPS before leaving U2/U3.
// - Probe-off bit set stops receiver detection in U2/U3; reset enables it.
// - Probe period code 00 gives 8 ms, 01 gives 12 ms, others reserved.
// - Compliance code 00 lets the internal state machine decide compliance.
// - Code 01 forces downstream compliance, 10 upstream, 11 disables it.
// - Register mode whenever mode pin is not low, else pin mode.
// - Each receiver offers sixteen equalization settings.
// - Register 0x20 holds two downstream four-bit eq selects.
`timescale 1ns/1ps
`default_nettype none
`include "ured_map.svh"

module ured_regs
    import ured_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = `URED_DEBOUNCE_CYC,
    parameter int unsigned PROBE_SHORT_CYC = `URED_PROBE_SHORT_CYC,
    parameter int unsigned PROBE_LONG_CYC = `URED_PROBE_LONG_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] mode_select_level,
    input wire ured_eq_t upstream_eq_strap_pins,
    input wire ured_eq_t downstream_eq_strap_pins,
    input wire logic lfps_receiving,
    input wire logic in_sleep_state,
    input wire logic fsm_compliance_req,
    output ured_eq_s eq_applied,
    output logic register_mode,
    output logic sleep_exit,
    output logic rx_detect_enable,
    output logic rx_detect_tick,
    output logic compliance_force_down,
    output logic compliance_force_up,
    output logic compliance_active_flag
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic software_eq_takeover_r;
    ured_eq_t upstream_eq_level_r;
    ured_eq_t downstream_rx_a_eq_level_r;
    ured_eq_t downstream_rx_b_eq_level_r;
    logic low_freq_signal_eq_apply_r;
    logic sleep_exit_filter_enable_r;
    logic sleep_receiver_probe_off_r;
    ured_period_e downstream_probe_period_r;
    ured_cm_e compliance_force_select_r;
    logic sw_writes;
    logic [21:0] debounce_cnt_r;
    logic [21:0] probe_cnt_r;
    logic [21:0] probe_limit;
    localparam logic [7:0] RST_DOWN_EQ = `URED_RST_DOWN_EQ;
    localparam logic [7:0] RST_LINK_CTRL = `URED_RST_LINK_CTRL;

    assign register_mode = (mode_select_level != 2'h0);
    assign sw_writes = reg_wr && register_mode;

    always_ff @(posedge clk)
    begin
        if (rst)
            software_eq_takeover_r <= 1'b0;
        else if (sw_writes && reg_addr == `URED_OFS_GENERAL)
            software_eq_takeover_r <= reg_wdata[`URED_BIT_TAKEOVER];
    end

    // Equalization fields track the straps unless software has taken over in register mode.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            upstream_eq_level_r <= `URED_RST_UP_EQ;
            downstream_rx_a_eq_level_r <= RST_DOWN_EQ[3:0];
            downstream_rx_b_eq_level_r <= RST_DOWN_EQ[7:4];
        end
        else if (!(software_eq_takeover_r && register_mode))
        begin
            upstream_eq_level_r <= upstream_eq_strap_pins;
            downstream_rx_a_eq_level_r <= downstream_eq_strap_pins;
            downstream_rx_b_eq_level_r <= downstream_eq_strap_pins;
        end
        else if (sw_writes)
        begin
            if (reg_addr == `URED_OFS_UP_EQ)
                upstream_eq_level_r <= reg_wdata[3:0];
            if (reg_addr == `URED_OFS_DOWN_EQ)
            begin
                downstream_rx_a_eq_level_r <= reg_wdata[3:0];
                downstream_rx_b_eq_level_r <= reg_wdata[7:4];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            low_freq_signal_eq_apply_r <= RST_LINK_CTRL[`URED_BIT_LOW_FREQ_SIGNAL_EQ_APPLY];
            sleep_exit_filter_enable_r <= RST_LINK_CTRL[`URED_BIT_EXIT_FILTER];
            sleep_receiver_probe_off_r <=
                RST_LINK_CTRL[`URED_BIT_PROBE_OFF];
            downstream_probe_period_r <=
                ured_period_e'(RST_LINK_CTRL[`URED_LSB_PERIOD +: 2]);
            compliance_force_select_r <=
                ured_cm_e'(RST_LINK_CTRL[`URED_LSB_COMPLIANCE +: 2]);
        end
        else if (sw_writes && reg_addr == `URED_OFS_LINK_CTRL)
        begin
            low_freq_signal_eq_apply_r <= reg_wdata[`URED_BIT_LOW_FREQ_SIGNAL_EQ_APPLY];
            sleep_exit_filter_enable_r <= reg_wdata[`URED_BIT_EXIT_FILTER];
            sleep_receiver_probe_off_r <= reg_wdata[`URED_BIT_PROBE_OFF];
            downstream_probe_period_r <=
                ured_period_e'(reg_wdata[`URED_LSB_PERIOD +: 2]);
            compliance_force_select_r <=
                ured_cm_e'(reg_wdata[`URED_LSB_COMPLIANCE +: 2]);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `URED_OFS_GENERAL:
                    reg_rdata <= 8'(software_eq_takeover_r)
                        << `URED_BIT_TAKEOVER;
                `URED_OFS_DOWN_EQ:
                    reg_rdata <= {downstream_rx_b_eq_level_r,
                        downstream_rx_a_eq_level_r};
                `URED_OFS_UP_EQ:
                    reg_rdata <= {4'h0, upstream_eq_level_r};
                `URED_OFS_LINK_CTRL:
                    reg_rdata <= {compliance_active_flag,
                        low_freq_signal_eq_apply_r,
                        sleep_exit_filter_enable_r,
                        sleep_receiver_probe_off_r,
                        downstream_probe_period_r,
                        compliance_force_select_r};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Equalization and compliance outputs
    // ------------------------------------------------------------
    // Sixteen codes per receiver pass through unchanged, but all are zero during LFPS while the apply bit is clear.
    always_comb
    begin
        if (lfps_receiving && !low_freq_signal_eq_apply_r)
            eq_applied = '0;
        else
            eq_applied = '{upstream: upstream_eq_level_r,
                down_a: downstream_rx_a_eq_level_r,
                down_b: downstream_rx_b_eq_level_r};
    end

    assign compliance_force_down =
        (compliance_force_select_r == URED_CM_DOWNSTREAM);
    assign compliance_force_up =
        (compliance_force_select_r == URED_CM_UPSTREAM);

    always_ff @(posedge clk)
    begin
        if (rst)
            compliance_active_flag <= 1'b0;
        else
            compliance_active_flag <= compliance_force_down
                || compliance_force_up
                || (compliance_force_select_r == URED_CM_AUTO
                    && fsm_compliance_req);
    end

    // ------------------------------------------------------------
    // Sleep exit filter and receiver detection
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || !lfps_receiving || !in_sleep_state)
            debounce_cnt_r <= '0;
        else if (debounce_cnt_r < 22'(DEBOUNCE_CYC))
            debounce_cnt_r <= debounce_cnt_r + 22'h1;
    end

    always_comb
    begin
        if (!in_sleep_state || !lfps_receiving)
            sleep_exit = 1'b0;
        else if (sleep_exit_filter_enable_r)
            sleep_exit = (debounce_cnt_r >= 22'(DEBOUNCE_CYC));
        else
            sleep_exit = 1'b1;
    end

    assign rx_detect_enable =
        !(in_sleep_state && sleep_receiver_probe_off_r);

    // Reserved period codes fall back to the 8 ms interval.
    assign probe_limit = (downstream_probe_period_r == URED_PERIOD_12MS)
        ? 22'(PROBE_LONG_CYC) : 22'(PROBE_SHORT_CYC);

    always_ff @(posedge clk)
    begin
        if (rst || probe_cnt_r >= probe_limit - 22'h1)
            probe_cnt_r <= '0;
        else
            probe_cnt_r <= probe_cnt_r + 22'h1;
    end

    assign rx_detect_tick = rx_detect_enable
        && (probe_cnt_r >= probe_limit - 22'h1);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_low_freq_signal_eq_apply_zero: assert property (@(posedge clk) disable iff (rst)
        lfps_receiving && !low_freq_signal_eq_apply_r |-> eq_applied == '0)
        else $error("eq not zero during LFPS");
    a_low_freq_signal_eq_apply_kept: assert property (@(posedge clk) disable iff (rst)
        low_freq_signal_eq_apply_r |->
            eq_applied.upstream == upstream_eq_level_r)
        else $error("eq lost while LFPS apply set");
    a_strap_follow: assert property (@(posedge clk) disable iff (rst)
        !software_eq_takeover_r |=>
            upstream_eq_level_r == $past(upstream_eq_strap_pins))
        else $error("upstream eq not tracking straps");
    a_sw_eq_write: assert property (@(posedge clk) disable iff (rst)
        software_eq_takeover_r && sw_writes
            && reg_addr == `URED_OFS_UP_EQ |=>
            upstream_eq_level_r == $past(reg_wdata[3:0]))
        else $error("upstream eq write lost");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `URED_OFS_UP_EQ |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved upstream bits not zero");
    a_cm_status: assert property (@(posedge clk) disable iff (rst)
        compliance_force_select_r == URED_CM_OFF [*2] |->
            !compliance_active_flag)
        else $error("compliance flag set while disabled");
    a_cm_auto: assert property (@(posedge clk) disable iff (rst)
        compliance_force_select_r == URED_CM_AUTO && fsm_compliance_req
            |=> compliance_active_flag
                || $past(compliance_force_select_r) != URED_CM_AUTO)
        else $error("automatic compliance not reported");
    a_force_one_hot: assert property (@(posedge clk) disable iff (rst)
        !(compliance_force_down && compliance_force_up))
        else $error("both compliance directions forced");
    a_probe_off: assert property (@(posedge clk) disable iff (rst)
        in_sleep_state && sleep_receiver_probe_off_r |-> !rx_detect_tick)
        else $error("receiver detect while disabled in sleep");
    a_filter_hold: assert property (@(posedge clk) disable iff (rst)
        sleep_exit && sleep_exit_filter_enable_r |->
            debounce_cnt_r >= 22'(DEBOUNCE_CYC))
        else $error("sleep exit before debounce");
    a_pin_mode: assert property (@(posedge clk) disable iff (rst)
        mode_select_level == 2'h0 && reg_wr
            && reg_addr == `URED_OFS_GENERAL |=>
            software_eq_takeover_r == $past(software_eq_takeover_r))
        else $error("register write accepted in pin mode");

    c_lfps_zero: cover property (@(posedge clk) disable iff (rst)
        lfps_receiving && !low_freq_signal_eq_apply_r);
    c_sw_takeover: cover property (@(posedge clk) disable iff (rst)
        software_eq_takeover_r && sw_writes && reg_addr == `URED_OFS_UP_EQ);
    c_filtered_exit: cover property (@(posedge clk) disable iff (rst)
        sleep_exit && sleep_exit_filter_enable_r);
    c_forced_up: cover property (@(posedge clk) disable iff (rst)
        compliance_force_up && compliance_active_flag);

endmodule // ured_regs

`default_nettype wire

//--- sim/ured_host_model.sv
// Register host model standing in for the serial controller back end.
// Assumes the parallel register port of ured_regs, driven off negedge.
`timescale 1ns/1ps
`default_nettype none

module ured_host_model
    import ured_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // ----------------------------------------
    // Strobed accesses, held across one edge.
    // ----------------------------------------
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // ured_host_model

`default_nettype wire

//--- sim/ured_regs_tb_top.sv
// Self-checking bench for the equalization and compliance registers.
// Assumes ured_regs with shortened debounce and probe counts.
`timescale 1ns/1ps
`default_nettype none

module ured_regs_tb_top
    import ured_pkg::*;
;
    // ----------------------------------------
    // Design, host and stimulus.
    // ----------------------------------------
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;
        logic [1:0] f;} ured_row_s;
    logic clk, rst, reg_wr, reg_rd, lfps, slp, fsm_req, rmode, sexit;
    logic det_en, tick, f_dn, f_up, cm_flag;
    logic [7:0] addr, wdata, rdata, v;
    logic [1:0] mode;
    ured_eq_t up_strap, dn_strap;
    ured_eq_s eq;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    ured_row_s rows [9] = '{
        '{8'h21, 8'hf8, 8'h08, 2'h0}, '{8'h21, 8'h0b, 8'h0b, 2'h0},
        '{8'h20, 8'h5a, 8'h5a, 2'h0}, '{8'h22, 8'hff, 8'h7f, 2'h0},
        '{8'h22, 8'h01, 8'h81, 2'h2}, '{8'h22, 8'h02, 8'h82, 2'h1},
        '{8'h22, 8'h00, 8'h00, 2'h0}, '{8'h0a, 8'hff, 8'h10, 2'h0},
        '{8'h33, 8'hff, 8'h00, 2'h0}};

    ured_regs #(.DEBOUNCE_CYC(8), .PROBE_SHORT_CYC(20),
        .PROBE_LONG_CYC(30)) ured_regs_inst (.clk(clk), .rst(rst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .mode_select_level(mode),
        .upstream_eq_strap_pins(up_strap),
        .downstream_eq_strap_pins(dn_strap), .lfps_receiving(lfps),
        .in_sleep_state(slp), .fsm_compliance_req(fsm_req),
        .eq_applied(eq), .register_mode(rmode), .sleep_exit(sexit),
        .rx_detect_enable(det_en), .rx_detect_tick(tick),
        .compliance_force_down(f_dn), .compliance_force_up(f_up),
        .compliance_active_flag(cm_flag));

    ured_host_model ured_host_model_inst (.clk(clk), .reg_rdata(rdata),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));

    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Measures cycles between two probe ticks, giving up after 100.
    task automatic period(output int p);
        p = 0;
        for (int i = 0; i < 100 && tick !== 1'b1; i++)
            @(negedge clk);
        @(negedge clk);
        for (p = 1; p < 100 && tick !== 1'b1; p++)
            @(negedge clk);
        if (p >= 100)
        begin
            miscompares++;
            final_report();
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        {lfps, slp, fsm_req} = 3'h0;
        mode = 2'h0;
        up_strap = 4'h3;
        dn_strap = 4'h6;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            @(negedge clk);
            mode = 2'(m);
            #1 chk(12'(rmode), 12'(m != 0));
        end
        @(negedge clk);
        mode = 2'h0;
        ured_host_model_inst.wr(8'h0a, 8'h10);
        ured_host_model_inst.rd(8'h0a, v);
        chk(12'(v), 12'h000);
        mode = 2'h1;
        ured_host_model_inst.rd(8'h21, v);
        chk(12'(v), 12'h003);
        ured_host_model_inst.wr(8'h21, 8'h05);
        ured_host_model_inst.rd(8'h21, v);
        chk(12'(v), 12'h003);
        ured_host_model_inst.rd(8'h20, v);
        chk(12'(v), 12'h066);
        ured_host_model_inst.rd(8'h22, v);
        chk(12'(v), 12'h000);
        ured_host_model_inst.wr(8'h0a, 8'h10);
        foreach (rows[i])
        begin
            ured_host_model_inst.wr(rows[i].a, rows[i].d);
            @(negedge clk);
            chk(12'({f_dn, f_up}), 12'(rows[i].f));
            ured_host_model_inst.rd(rows[i].a, v);
            chk(12'(v), 12'(rows[i].e));
        end
        fsm_req = 1'b1;
        repeat (2) @(negedge clk);
        chk(12'(cm_flag), 12'h001);
        // Code 11 must keep the flag low even with the state machine asking.
        ured_host_model_inst.wr(8'h22, 8'h03);
        repeat (2) @(negedge clk);
        chk(12'(cm_flag), 12'h000);
        fsm_req = 1'b0;
        lfps = 1'b1;
        #1 chk(eq, 12'h000);
        ured_host_model_inst.wr(8'h22, 8'h40);
        chk(eq, 12'hba5);
        ured_host_model_inst.wr(8'h22, 8'h20);
        slp = 1'b1;
        for (n = 0; n < 20 && sexit !== 1'b1; n++)
            @(negedge clk);
        chk(12'(n), 12'd8);
        ured_host_model_inst.wr(8'h22, 8'h10);
        #1 chk(12'({sexit, det_en}), 12'h002);
        n = 0;
        repeat (45) @(negedge clk) n += int'(tick === 1'b1);
        chk(12'(n), 12'h000);
        ured_host_model_inst.wr(8'h22, 8'h00);
        chk(12'(det_en), 12'h001);
        for (int i = 0; i < 3; i++)
        begin
            ured_host_model_inst.wr(8'h22, 8'(i << 2));
            period(n);
            chk(12'(n), (i == 1) ? 12'd30 : 12'd20);
        end
        // Pin mode hands the field back to the straps despite the takeover.
        mode = 2'h0;
        ured_host_model_inst.rd(8'h21, v);
        chk(12'(v), 12'h003);
        mode = 2'h1;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        ured_host_model_inst.rd(8'h22, v);
        chk(12'(v), 12'h000);
        ured_host_model_inst.rd(8'h0a, v);
        chk(12'(v), 12'h000);
        final_report();
    end
endmodule // ured_regs_tb_top

`default_nettype wire
